//--- hw/alr_pkg.sv
/*
  Constants, register map and state encoding of the audio link reset and
  codec discovery block.
  Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus with
  byte addresses.
*/
package alr_pkg;

  localparam int          ALR_NUM_SDI         = 4;

  // Register byte offsets.
  localparam logic [5:0]  ALR_GCTL_OFFSET     = 6'h08;
  localparam logic [5:0]  ALR_WAKE_ENABLE_BITS_OFFSET   = 6'h0c;
  localparam logic [5:0]  ALR_CODEC_STATE_CHANGE_BITS_OFFSET = 6'h10;
  localparam logic [5:0]  ALR_INTERRUPT_CONTROL_REGISTER_OFFSET   = 6'h20;
  localparam logic [5:0]  ALR_LSTAT_OFFSET    = 6'h24;

  // Field positions.
  localparam int          ALR_CONTROLLER_RESET_BIT_BIT        = 0;
  localparam int          ALR_CIE_BIT         = 31;

  // Values after reset and of unmapped reads.
  localparam logic [31:0] ALR_REG_RESET       = 32'h0000_0000;
  localparam logic [31:0] ALR_UNMAPPED_DATA   = 32'h0000_0000;

  // Timing.
  localparam int          ALR_SYS_CLK_MHZ     = 50;
  localparam int          ALR_BCLK_HALF       = 4;
  localparam int          ALR_LINK_HOLD_NS    = 1000;
  localparam int          ALR_INIT_NS         = 400;
  localparam int          ALR_LINK_HOLD_CYC   = (ALR_LINK_HOLD_NS * ALR_SYS_CLK_MHZ + 999) / 1000;
  localparam int          ALR_INIT_CYC        = (ALR_INIT_NS * ALR_SYS_CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0]
  {
    ALR_ST_RESET      = 4'b0001,
    ALR_ST_LINK_START = 4'b0010,
    ALR_ST_INIT       = 4'b0100,
    ALR_ST_RUN        = 4'b1000
  } alr_state_type;

endpackage

//--- hw/alr_reset_discovery.sv
/*
  Controller reset exit, link bit clock generation and codec discovery
  with a state-change interrupt, reached over an Avalon-MM slave.
  Assumes codec serial data inputs are asynchronous to sys_clk and that
  the link bit clock is made here from sys_clk by a divider.
*/
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module alr_reset_discovery
  import alr_pkg::*;
(
  // Clock and reset.
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Avalon-MM register slave.
  input  wire logic [5:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Codec link.
  output logic                        link_bclk,
  output logic                        link_reset_n,
  input  wire logic [ALR_NUM_SDI-1:0] codec_serial_data_in,
  // Interrupt.
  output logic                        irq
);

  alr_state_type                  state_reg;
  logic                           ack_reg;
  logic                           controller_reset_bit_req_reg;
  logic [7:0]                     count_reg;
  logic [1:0]                     div_reg;
  logic                           bclk_reg;
  logic                           link_reset_n_reg;
  logic [ALR_NUM_SDI-1:0]         sdi_meta_reg;
  logic [ALR_NUM_SDI-1:0]         sdi_sync_reg;
  logic [ALR_NUM_SDI-1:0]         sdi_seen_reg;
  logic [ALR_NUM_SDI-1:0]         wake_en_reg;
  logic [ALR_NUM_SDI-1:0]         state_change_reg;
  logic [ALR_NUM_SDI-1:0]         irq_mask_reg;
  logic                           cie_reg;
  logic [31:0]                    readdata_reg;

  logic                           bus_wr;
  logic [31:0]                    wmask;
  logic [31:0]                    wdata;
  logic                           ctrl_ready;
  logic                           link_up;
  logic                           bclk_rise;
  logic [ALR_NUM_SDI-1:0]         sdi_rise;
  logic [ALR_NUM_SDI-1:0]         change_set;
  logic [ALR_NUM_SDI-1:0]         change_clr;
  logic [31:0]                    read_value;
  logic [31:0]                    interrupt_control_register_word;
  logic [31:0]                    lstat_word;
  logic [ALR_NUM_SDI-1:0]         irq_pending;

  logic                           sel_gctl;
  logic                           sel_wake_enable_bits;
  logic                           sel_codec_state_change_bits;
  logic                           sel_interrupt_control_register;

  // Address decode shared by the write paths; at most one select is high.
  always_comb
  begin
    sel_gctl     = 1'b0;
    sel_wake_enable_bits   = 1'b0;
    sel_codec_state_change_bits = 1'b0;
    sel_interrupt_control_register   = 1'b0;
    if (avs_address == ALR_GCTL_OFFSET)
      sel_gctl = 1'b1;
    else if (avs_address == ALR_WAKE_ENABLE_BITS_OFFSET)
      sel_wake_enable_bits = 1'b1;
    else if (avs_address == ALR_CODEC_STATE_CHANGE_BITS_OFFSET)
      sel_codec_state_change_bits = 1'b1;
    else if (avs_address == ALR_INTERRUPT_CONTROL_REGISTER_OFFSET)
      sel_interrupt_control_register = 1'b1;
  end

  // One wait state on every access; the write lands and read data stand
  // at the edge where waitrequest is low.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign bus_wr          = avs_write & ack_reg;
  assign wmask           = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata           = avs_writedata & wmask;
  assign ctrl_ready      = (state_reg == ALR_ST_RUN);
  assign link_up         = (state_reg == ALR_ST_INIT) | (state_reg == ALR_ST_RUN);

  // The controller reset bit is the only bit writable while in reset.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      controller_reset_bit_req_reg <= 1'b0;
    else if (bus_wr && sel_gctl && avs_byteenable[0])
      controller_reset_bit_req_reg <= avs_writedata[ALR_CONTROLLER_RESET_BIT_BIT];
  end

  // Reset exit sequence: clock the link with reset held, then release the
  // link reset and let the internal logic settle before reporting ready.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ALR_ST_RESET;
      count_reg <= 8'h00;
    end
    else if (!controller_reset_bit_req_reg)
    begin
      state_reg <= ALR_ST_RESET;
      count_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        ALR_ST_RESET:
        begin
          state_reg <= ALR_ST_LINK_START;
          count_reg <= 8'h00;
        end
        ALR_ST_LINK_START:
        begin
          if (count_reg == 8'(ALR_LINK_HOLD_CYC - 1))
          begin
            state_reg <= ALR_ST_INIT;
            count_reg <= 8'h00;
          end
          else
            count_reg <= count_reg + 8'h01;
        end
        ALR_ST_INIT:
        begin
          if (count_reg == 8'(ALR_INIT_CYC - 1))
          begin
            state_reg <= ALR_ST_RUN;
            count_reg <= 8'h00;
          end
          else
            count_reg <= count_reg + 8'h01;
        end
        ALR_ST_RUN:
          count_reg <= 8'h00;
        default:
        begin
          state_reg <= ALR_ST_RESET;
          count_reg <= 8'h00;
        end
      endcase
    end
  end

  // Link bit clock: sys_clk divided by twice the half period, stopped low
  // whenever the controller is in reset.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_reg  <= 2'b00;
      bclk_reg <= 1'b0;
    end
    else if (state_reg == ALR_ST_RESET)
    begin
      div_reg  <= 2'b00;
      bclk_reg <= 1'b0;
    end
    else if (div_reg == 2'(ALR_BCLK_HALF - 1))
    begin
      div_reg  <= 2'b00;
      bclk_reg <= ~bclk_reg;
    end
    else
      div_reg <= div_reg + 2'b01;
  end

  assign bclk_rise = (state_reg != ALR_ST_RESET) & (div_reg == 2'(ALR_BCLK_HALF - 1)) & ~bclk_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      link_reset_n_reg <= 1'b0;
    else
      link_reset_n_reg <= link_up;
  end

  assign link_bclk    = bclk_reg;
  assign link_reset_n = link_reset_n_reg;

  // Two-flop synchronisers for the codec serial data inputs.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sdi_meta_reg <= '0;
      sdi_sync_reg <= '0;
    end
    else
    begin
      sdi_meta_reg <= codec_serial_data_in;
      sdi_sync_reg <= sdi_meta_reg;
    end
  end

  // With the link up a codec's request is a rising data line seen at a bit
  // clock edge; its address is the index of the line it answers on, which
  // is unique by wiring. In reset a rising line is a wake event instead.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sdi_seen_reg <= '0;
    else if (state_reg == ALR_ST_LINK_START)
      sdi_seen_reg <= '0;
    else if (!link_up || bclk_rise)
      sdi_seen_reg <= sdi_sync_reg;
  end

  assign sdi_rise = sdi_sync_reg & ~sdi_seen_reg;

  // Set sources of the state-change bits. With the link up a request only
  // counts at a bit clock rise, so a line still settling after the link
  // start is not taken twice. In reset only lines with a wake enable count,
  // and while the link is starting nothing counts at all.
  always_comb
  begin
    change_set = '0;
    if (link_up)
    begin
      if (bclk_rise)
        change_set = sdi_rise;
    end
    else if (state_reg == ALR_ST_RESET)
    begin
      change_set = sdi_rise & wake_en_reg;
    end
  end

  // Software clears a state-change bit by writing a one to it, and only
  // while the controller is ready; a set in the same cycle wins.
  always_comb
  begin
    change_clr = '0;
    if (bus_wr && ctrl_ready)
    begin
      if (sel_codec_state_change_bits)
        change_clr = wdata[ALR_NUM_SDI-1:0];
    end
  end

  // Retained bits: only the power-on reset clears them.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_change_reg <= ALR_REG_RESET[ALR_NUM_SDI-1:0];
    else
      state_change_reg <= (state_change_reg & ~change_clr) | change_set;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wake_en_reg <= ALR_REG_RESET[ALR_NUM_SDI-1:0];
    else if (bus_wr && ctrl_ready && sel_wake_enable_bits)
      wake_en_reg <= (wake_en_reg & ~wmask[ALR_NUM_SDI-1:0]) | wdata[ALR_NUM_SDI-1:0];
  end

  // Interrupt control is not retained and falls back to default in reset.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cie_reg      <= ALR_REG_RESET[ALR_CIE_BIT];
      irq_mask_reg <= ALR_REG_RESET[ALR_NUM_SDI-1:0];
    end
    else if (!ctrl_ready)
    begin
      cie_reg      <= ALR_REG_RESET[ALR_CIE_BIT];
      irq_mask_reg <= ALR_REG_RESET[ALR_NUM_SDI-1:0];
    end
    else if (bus_wr && sel_interrupt_control_register)
    begin
      if (avs_byteenable[3])
        cie_reg <= avs_writedata[ALR_CIE_BIT];
      if (avs_byteenable[0])
        irq_mask_reg <= avs_writedata[ALR_NUM_SDI-1:0];
    end
  end

  // A codec raises the interrupt only while its mask bit and the controller
  // enable are both set; the status bits stay visible to software either way.
  assign irq_pending = state_change_reg & irq_mask_reg;
  assign irq         = cie_reg & |irq_pending;

  // Interrupt control word; it holds its default while in reset.
  assign interrupt_control_register_word = {cie_reg, {(31-ALR_NUM_SDI){1'b0}}, irq_mask_reg};

  // Link status for bring-up: link reset, bit clock and sequencer state.
  assign lstat_word  = {26'h0, link_reset_n_reg, bclk_reg, state_reg};

  // Read mux; non-retained registers show defaults until the block is ready.
  always_comb
  begin
    read_value = ALR_UNMAPPED_DATA;
    if (avs_address == ALR_GCTL_OFFSET)
    begin
      read_value = {31'h0, ctrl_ready};
    end
    else if (avs_address == ALR_WAKE_ENABLE_BITS_OFFSET)
    begin
      read_value = {{(32-ALR_NUM_SDI){1'b0}}, wake_en_reg};
    end
    else if (avs_address == ALR_CODEC_STATE_CHANGE_BITS_OFFSET)
    begin
      read_value = {{(32-ALR_NUM_SDI){1'b0}}, state_change_reg};
    end
    else if (avs_address == ALR_INTERRUPT_CONTROL_REGISTER_OFFSET)
    begin
      read_value = interrupt_control_register_word;
    end
    else if (avs_address == ALR_LSTAT_OFFSET)
    begin
      read_value = lstat_word;
    end
  end

  // Read data are captured at the request edge and stand until the next
  // read, so the master may take them at the edge where waitrequest is low.

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      readdata_reg <= ALR_REG_RESET;
    else if (avs_read && !ack_reg)
      readdata_reg <= read_value;
  end

  assign avs_readdata = readdata_reg;

endmodule

//--- testbench/alr_reset_discovery_chk.sv
/*
  Port checker for the audio link reset and codec discovery block.
  Assumes the package offsets and a register slave with one wait state.
*/
`timescale 1ns/100ps
module alr_reset_discovery_chk
  import alr_pkg::*;
(
  // Clock and reset.
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  // Register bus.
  input wire logic [5:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // Link and interrupt.
  input wire logic                   link_bclk,
  input wire logic                   link_reset_n,
  input wire logic [ALR_NUM_SDI-1:0] codec_serial_data_in,
  input wire logic                   irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic       started_reg;
  logic [3:0] stop_reg;
  logic [6:0] age_reg;
  wire        rd_done = avs_read && !avs_waitrequest;
  wire        wr_controller_reset_bit = avs_write && !avs_waitrequest && avs_address == ALR_GCTL_OFFSET
                        && avs_byteenable[0];
  wire        idle    = !started_reg && stop_reg == 4'h0;
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      started_reg <= 1'b0;
    else if (wr_controller_reset_bit)
      started_reg <= avs_writedata[ALR_CONTROLLER_RESET_BIT_BIT];
  // Remembers recent run time so that a stopping link gets a few edges to settle.
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      stop_reg <= 4'h0;
    else
      stop_reg <= {stop_reg[2:0], started_reg};
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      age_reg <= 7'h00;
    else if (!started_reg)
      age_reg <= 7'h00;
    else if (age_reg != 7'h7f)
      age_reg <= age_reg + 7'h01;
  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not after one wait state");
  AST_IDLE_LINK: assert property (idle |-> !link_bclk && !link_reset_n)
    else $error("link active while controller in reset");
  AST_IRQ_QUIET: assert property (idle |-> !irq) else $error("irq while in reset");
  AST_HOLD: assert property ($rose(link_reset_n) |-> started_reg && $past(started_reg, 50))
    else $error("link reset released too early");
  AST_BCLK_LOW: assert property ($fell(link_bclk) |-> !link_bclk [*4])
    else $error("bit clock low phase not four cycles");
  AST_CONTROLLER_RESET_BIT_EARLY: assert property (rd_done && avs_address == ALR_GCTL_OFFSET &&
    age_reg < 7'h32 |-> !avs_readdata[ALR_CONTROLLER_RESET_BIT_BIT]) else $error("reset bit read 1 too early");
  AST_CONTROLLER_RESET_BIT_READY: assert property (rd_done && avs_address == ALR_GCTL_OFFSET &&
    age_reg == 7'h7f |-> avs_readdata[ALR_CONTROLLER_RESET_BIT_BIT]) else $error("reset bit never read 1");
  AST_LOCKED: assert property (rd_done && avs_address == ALR_INTERRUPT_CONTROL_REGISTER_OFFSET && idle
    |-> avs_readdata == ALR_REG_RESET) else $error("interrupt control not default in reset");
  AST_UNMAPPED: assert property (rd_done && avs_address == 6'h3c
    |-> avs_readdata == ALR_UNMAPPED_DATA) else $error("unmapped read");
  cover property ($rose(link_reset_n));
  cover property ($rose(irq));
  cover property (rd_done && age_reg == 7'h7f && avs_readdata[ALR_CONTROLLER_RESET_BIT_BIT]);
endmodule

bind alr_reset_discovery alr_reset_discovery_chk i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_bclk(link_bclk),
  .link_reset_n(link_reset_n), .codec_serial_data_in(codec_serial_data_in), .irq(irq));

//--- testbench/alr_codec_model.sv
/*
  Codec model that asks for enumeration once the link reset is released.
  Assumes link_bclk and link_reset_n come from the block; the model
  drives the lines of absent codecs low itself.
*/
`timescale 1ns/100ps
module alr_codec_model
#(
  parameter logic [3:0] PRESENT = 4'h5,
  parameter int         DELAY   = 16
)
(
  // Link from the controller.
  input  wire logic       link_bclk,
  input  wire logic       link_reset_n,
  // Codec data lines.
  output logic      [3:0] sdi
);
  int n;
  // Each present codec pulses its line for two bit clocks after its start-up delay.
  always @(posedge link_bclk or negedge link_reset_n)
    if (!link_reset_n)
    begin
      n <= 0;
      sdi <= 4'h0;
    end
    else
    begin
      if (n < DELAY + 4)
        n <= n + 1;
      sdi <= (n >= DELAY && n < DELAY + 2) ? PRESENT : 4'h0;
    end
endmodule

//--- testbench/test_alr_reset_discovery.sv
/*
  Testbench for the audio link reset and codec discovery block.
  Assumes the codec model on the data lines, codecs at 0 and 2.
*/
`timescale 1ns/100ps
module test_alr_reset_discovery
  import alr_pkg::*;
;
  logic        sys_clk         = 1'b0;
  logic        resetn          = 1'b0;
  logic [5:0]  avs_address     = 6'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        link_bclk;
  logic        link_reset_n;
  logic [3:0]  sdi;
  logic        irq;
  logic [31:0] rd;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  always #10 sys_clk = ~sys_clk;

  alr_reset_discovery i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_bclk(link_bclk),
    .link_reset_n(link_reset_n), .codec_serial_data_in(sdi), .irq(irq));
  alr_codec_model #(.PRESENT(4'h5), .DELAY(16)) i_codec (
    .link_bclk(link_bclk), .link_reset_n(link_reset_n), .sdi(sdi));

  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  // One request held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic chk_rd(input string w, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(w, e, d);
  endtask

  task automatic wr_irq(input logic [5:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d, rd);
    @(negedge sys_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Counts bit clock rises over 160 system cycles; a 160 ns period gives 20.
  task automatic chk_bclk;
    int   rises;
    logic last;
    rises = 0;
    last  = link_bclk;
    repeat (160)
    begin
      @(negedge sys_clk);
      if (link_bclk && !last)
        rises++;
      last = link_bclk;
    end
    chk("bclk rises", 32'h14, 32'(rises));
  endtask

  task t_reset;
    chk_rd("controller_reset_bit", ALR_GCTL_OFFSET, 32'h0);
    chk_rd("wake", ALR_WAKE_ENABLE_BITS_OFFSET, ALR_REG_RESET);
    chk_rd("codec_state_change_bits", ALR_CODEC_STATE_CHANGE_BITS_OFFSET, ALR_REG_RESET);
    chk_rd("unmapped", 6'h3c, ALR_UNMAPPED_DATA);
    chk("link", 32'h0, {30'h0, link_reset_n, link_bclk});
    bus(1'b1, ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h8000_000f, rd);
    bus(1'b1, ALR_WAKE_ENABLE_BITS_OFFSET, 32'h0000_000f, rd);
    chk_rd("interrupt_control_register", ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h0);
    chk_rd("wake", ALR_WAKE_ENABLE_BITS_OFFSET, 32'h0);
    $display("test reset done");
  endtask

  task t_start;
    bus(1'b1, ALR_GCTL_OFFSET, 32'h1, rd);
    chk_rd("controller_reset_bit early", ALR_GCTL_OFFSET, 32'h0);
    do bus(1'b0, ALR_GCTL_OFFSET, 32'h0, rd); while (rd[0] !== 1'b1);
    chk("link_reset_n", 32'h1, {31'h0, link_reset_n});
    chk_bclk;
    repeat (12500) @(posedge sys_clk);
    chk_rd("codec_state_change_bits", ALR_CODEC_STATE_CHANGE_BITS_OFFSET, 32'h5);
    $display("test start done");
  endtask

  task t_irq;
    wr_irq(ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h8000_0004, 1'b1);
    wr_irq(ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h0000_0004, 1'b0);
    wr_irq(ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h8000_0004, 1'b1);
    wr_irq(ALR_CODEC_STATE_CHANGE_BITS_OFFSET, 32'h4, 1'b0);
    chk_rd("codec_state_change_bits", ALR_CODEC_STATE_CHANGE_BITS_OFFSET, 32'h1);
    $display("test irq done");
  endtask

  task t_abort;
    bus(1'b1, ALR_GCTL_OFFSET, 32'h0, rd);
    chk_rd("controller_reset_bit", ALR_GCTL_OFFSET, 32'h0);
    chk_rd("interrupt_control_register", ALR_INTERRUPT_CONTROL_REGISTER_OFFSET, 32'h0);
    chk("link", 32'h0, {30'h0, link_reset_n, link_bclk});
    bus(1'b1, ALR_CODEC_STATE_CHANGE_BITS_OFFSET, 32'h1, rd);
    chk_rd("codec_state_change_bits", ALR_CODEC_STATE_CHANGE_BITS_OFFSET, 32'h1);
    $display("test abort done");
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_start;
    t_irq;
    t_abort;
    report_and_stop;
  end
endmodule
